/* rtl/bsp_pkg.sv */
// Constants and carrier types of the brushless speed and PWM control block
package bsp_pkg;

  // ==========================================================================
  // Clock and speed reference
  localparam int unsigned CLK_HZ = 25_000_000;
  localparam int unsigned REF_DIV = 8192;
  localparam int unsigned REF_W = 13;
  localparam int unsigned DISC_PERIODS = 2;
  localparam int unsigned DISC_TARGET = REF_DIV * DISC_PERIODS;
  localparam int unsigned PER_W = 16;
  // Lock band is 6.25 percent, one sixteenth of the target
  localparam int unsigned LOCK_BAND_DIV = 16;
  localparam int unsigned LOCK_BAND = DISC_TARGET / LOCK_BAND_DIV;

  // ==========================================================================
  // Loop gains, as right shifts of the deviations
  localparam int unsigned SPEED_SHIFT = 4;
  localparam int unsigned PHASE_SHIFT = 6;

  // ==========================================================================
  // PWM carrier
  localparam int unsigned PWM_FREQ_HZ = 20_000;
  localparam int unsigned PWM_CYCLES = CLK_HZ / PWM_FREQ_HZ;
  localparam int unsigned DUTY_W = 11;

  // ==========================================================================
  // Restraint interval
  localparam int unsigned RESTRAINT_MS = 3300;
  localparam int unsigned RESTRAINT_CYCLES = RESTRAINT_MS * (CLK_HZ / 1000);

  // ==========================================================================
  // Reset values
  localparam logic [DUTY_W-1:0] DUTY_RESET = 11'h000;
  localparam logic LOCK_N_RESET = 1'b1;

  // ==========================================================================
  // Carriers
  typedef struct packed {
    logic [2:0] hall;
    logic tacho_pulse;
    logic dir_sel;
    logic run;
    logic cur_limit;
    logic restraint_en;
  } bsp_sense_t;

  typedef struct packed {
    logic [2:0] upper;
    logic [2:0] lower;
  } bsp_drive_t;

endpackage : bsp_pkg

/* rtl/bsp_top.sv */
// Speed regulation, commutation and PWM drive of a three-phase motor
// ============================================================================
module bsp_top #(
  parameter int unsigned PWM_PERIOD = bsp_pkg::PWM_CYCLES,
  parameter int unsigned RESTRAINT_CYC = bsp_pkg::RESTRAINT_CYCLES
) (
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire bsp_pkg::bsp_sense_t sense,
  output bsp_pkg::bsp_drive_t drive,
  output logic lock_detect_out,
  output logic power_save,
  output logic regulator_output,
  output logic restraint_latched
);
  import bsp_pkg::*;

  // ==========================================================================
  // Parameter checks
  if (PWM_PERIOD < 2 || PWM_PERIOD >= (1 << DUTY_W)) begin : g_bad_pwm
    $error("PWM_PERIOD out of range");
  end
  if (RESTRAINT_CYC < 1) begin : g_bad_restraint
    $error("RESTRAINT_CYC must be at least one");
  end

  localparam logic [DUTY_W-1:0] PWM_MAX = DUTY_W'(PWM_PERIOD);
  localparam logic [DUTY_W-1:0] PWM_LAST = DUTY_W'(PWM_PERIOD - 1);
  localparam logic [31:0] RESTRAINT_LAST = 32'(RESTRAINT_CYC - 1);
  localparam int unsigned SW = $bits(bsp_sense_t);

  // ==========================================================================
  // Reset release
  logic [1:0] rst_q;
  logic rst_n;

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      rst_q <= 2'h0;
    end else begin
      rst_q <= {rst_q[0], 1'b1};
    end
  end
  assign rst_n = rst_q[1];

  // ==========================================================================
  // Input synchronisers, change taken once stages two and three agree
  logic [SW-1:0] s1_q, s2_q, s3_q, in_q;
  bsp_sense_t sn;

  for (genvar i = 0; i < SW; i++) begin : g_sync
    always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
        s1_q[i] <= 1'b0;
        s2_q[i] <= 1'b0;
        s3_q[i] <= 1'b0;
        in_q[i] <= 1'b0;
      end else begin
        s1_q[i] <= sense[i];
        s2_q[i] <= s1_q[i];
        s3_q[i] <= s2_q[i];
        if (s2_q[i] == s3_q[i]) begin
          in_q[i] <= s3_q[i];
        end
      end
    end
  end
  assign sn = bsp_sense_t'(in_q);

  // ==========================================================================
  // Tacho edge and reference divider
  logic tacho_d_q;
  logic tacho_edge;
  logic [REF_W-1:0] ref_cnt_q;

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      tacho_d_q <= 1'b0;
    end else begin
      tacho_d_q <= sn.tacho_pulse;
    end
  end
  assign tacho_edge = sn.tacho_pulse & ~tacho_d_q;

  // Free-running wrap at 8192 sets the target tacho rate
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      ref_cnt_q <= '0;
    end else if (!sn.run) begin
      ref_cnt_q <= '0;
    end else begin
      ref_cnt_q <= ref_cnt_q + 1'b1;
    end
  end

  // ==========================================================================
  // Speed discriminator over two tacho periods
  logic [PER_W-1:0] per_cnt_q;
  logic half_q;
  logic spd_valid;
  logic stall;
  logic signed [19:0] spd_err;
  logic signed [19:0] ph_err;
  logic in_band;

  assign stall = (per_cnt_q == '1);
  assign spd_valid = tacho_edge & half_q;
  assign spd_err = 20'(signed'({4'h0, per_cnt_q}))
                   - 20'(signed'({1'b0, DISC_TARGET[18:0]}));
  assign in_band = (spd_err <= 20'(signed'({1'b0, LOCK_BAND[18:0]})))
                   && (spd_err >= -20'(signed'({1'b0, LOCK_BAND[18:0]})));
  // Late edge relative to the divider wrap reads positive: motor too slow
  assign ph_err = 20'(signed'(ref_cnt_q));

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      per_cnt_q <= '0;
      half_q <= 1'b0;
    end else if (!sn.run) begin
      per_cnt_q <= '0;
      half_q <= 1'b0;
    end else if (tacho_edge) begin
      half_q <= ~half_q;
      if (half_q) begin
        per_cnt_q <= PER_W'(1);
      end else if (!stall) begin
        per_cnt_q <= per_cnt_q + 1'b1;
      end
    end else if (!stall) begin
      per_cnt_q <= per_cnt_q + 1'b1;
    end
  end

  // ==========================================================================
  // Duty command
  logic [DUTY_W-1:0] duty_q;
  logic signed [19:0] duty_step;

  function automatic logic [DUTY_W-1:0] clamp_duty(
    input logic signed [19:0] v
  );
    if (v < 0) begin
      return '0;
    end else if (v > 20'(signed'({9'h000, PWM_MAX}))) begin
      return PWM_MAX;
    end else begin
      return v[DUTY_W-1:0];
    end
  endfunction : clamp_duty

  // Outside the band the speed term leads, inside only the phase term trims
  always_comb begin
    if (spd_valid && !in_band) begin
      duty_step = spd_err >>> SPEED_SHIFT;
    end else begin
      duty_step = ph_err >>> PHASE_SHIFT;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      duty_q <= DUTY_RESET;
    end else if (!sn.run) begin
      duty_q <= '0;
    end else if (stall) begin
      // Stalled or starting: no result will come, so drive full
      duty_q <= PWM_MAX;
    end else if (tacho_edge) begin
      duty_q <= clamp_duty(20'(signed'({9'h000, duty_q})) + duty_step);
    end
  end

  // ==========================================================================
  // Lock detect, low while locked
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      lock_detect_out <= LOCK_N_RESET;
    end else if (!sn.run || stall) begin
      lock_detect_out <= 1'b1;
    end else if (spd_valid) begin
      lock_detect_out <= ~in_band;
    end
  end

  // ==========================================================================
  // Restraint protection
  logic [31:0] rst_cnt_q;

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_cnt_q <= '0;
      restraint_latched <= 1'b0;
    end else if (!sn.run) begin
      rst_cnt_q <= '0;
      restraint_latched <= 1'b0;
    end else if (!lock_detect_out || !sn.restraint_en) begin
      rst_cnt_q <= '0;
    end else if (rst_cnt_q == RESTRAINT_LAST) begin
      restraint_latched <= 1'b1;
    end else begin
      rst_cnt_q <= rst_cnt_q + 1'b1;
    end
  end

  // ==========================================================================
  // PWM carrier and peak current chop
  logic [DUTY_W-1:0] pwm_cnt_q;
  logic chop_q;
  logic pwm_on;

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      pwm_cnt_q <= '0;
    end else if (!sn.run || pwm_cnt_q == PWM_LAST) begin
      pwm_cnt_q <= '0;
    end else begin
      pwm_cnt_q <= pwm_cnt_q + 1'b1;
    end
  end

  // Trip holds off until the next period, a cycle-by-cycle peak limit
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      chop_q <= 1'b0;
    end else if (sn.cur_limit) begin
      chop_q <= 1'b1;
    end else if (pwm_cnt_q == PWM_LAST) begin
      chop_q <= 1'b0;
    end
  end

  assign pwm_on = (pwm_cnt_q < duty_q) && !chop_q && !sn.cur_limit
                  && !restraint_latched && sn.run;

  // ==========================================================================
  // Commutation
  logic [2:0] hi_ph, lo_ph;

  always_comb begin
    case (sn.hall)
      3'h5: begin hi_ph = 3'h1; lo_ph = 3'h2; end
      3'h4: begin hi_ph = 3'h1; lo_ph = 3'h4; end
      3'h6: begin hi_ph = 3'h2; lo_ph = 3'h4; end
      3'h2: begin hi_ph = 3'h2; lo_ph = 3'h1; end
      3'h3: begin hi_ph = 3'h4; lo_ph = 3'h1; end
      3'h1: begin hi_ph = 3'h4; lo_ph = 3'h2; end
      default: begin hi_ph = 3'h0; lo_ph = 3'h0; end
    endcase
  end

  // Reverse swaps the pair, walking the steps backwards
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      drive <= '0;
    end else if (!sn.run) begin
      drive <= '0;
    end else if (sn.dir_sel) begin
      drive.upper <= lo_ph;
      drive.lower <= hi_ph & {3{pwm_on}};
    end else begin
      drive.upper <= hi_ph;
      drive.lower <= lo_ph & {3{pwm_on}};
    end
  end

  // ==========================================================================
  // Power save, regulator stays up
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      power_save <= 1'b1;
      regulator_output <= 1'b0;
    end else begin
      power_save <= ~sn.run;
      regulator_output <= 1'b1;
    end
  end

endmodule : bsp_top

/* test/bsp_checker.sv */
// Port checker of the brushless speed and PWM control block
module bsp_checker
  import bsp_pkg::*;
#(
  parameter int unsigned PWM_PERIOD = 16,
  parameter int unsigned RESTRAINT_CYC = 200
) (
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire bsp_pkg::bsp_sense_t sense,
  input wire bsp_pkg::bsp_drive_t drive,
  input wire logic lock_detect_out,
  input wire logic power_save,
  input wire logic regulator_output,
  input wire logic restraint_latched
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [31:0] cnt_q;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!reset_n);
  // ==========================================================================
  // Unlocked run time, may lead the design by the sync delay
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      cnt_q <= '0;
    end else if (lock_detect_out && !power_save && sense.restraint_en) begin
      cnt_q <= cnt_q + 32'h1;
    end else begin
      cnt_q <= '0;
    end
  end
  // ==========================================================================
  // Assertions
  chk_upper_onehot:
    assert property ($onehot0(drive.upper)) else $error("upper not one-hot");
  chk_no_shoot:
    assert property ((drive.upper & drive.lower) == 3'h0)
    else $error("upper and lower on in one phase");
  chk_stop_zero:
    assert property (power_save [*2] |-> drive == 6'h00)
    else $error("drive active in stop");
  chk_reg_alive:
    assert property (power_save [*6] |-> regulator_output)
    else $error("regulator off in power save");
  chk_restraint_off:
    assert property (restraint_latched [*2] |-> drive.lower == 3'h0)
    else $error("lower on while latched");
  chk_latch_hold:
    assert property (sense.run [*6] ##0 restraint_latched |=>
      restraint_latched) else $error("latch dropped while started");
  chk_latch_cause:
    assert property ($rose(restraint_latched) |->
      $past(lock_detect_out) && cnt_q >= RESTRAINT_CYC - 8)
    else $error("latch without long unlock");
  chk_chop_cur:
    assert property (sense.cur_limit [*7] |-> drive.lower == 3'h0)
    else $error("lower on over current limit");
  chk_hall_invalid:
    assert property ((sense.hall == 3'h0) [*7] |-> drive == 6'h00)
    else $error("drive on with invalid hall");
endmodule : bsp_checker

bind bsp_top bsp_checker #(
  .PWM_PERIOD(PWM_PERIOD), .RESTRAINT_CYC(RESTRAINT_CYC)
) chk_u (
  .ref_clk(ref_clk), .reset_n(reset_n), .sense(sense), .drive(drive),
  .lock_detect_out(lock_detect_out), .power_save(power_save),
  .regulator_output(regulator_output),
  .restraint_latched(restraint_latched)
);

/* test/bsp_motor.sv */
// Behavioural motor with Hall sensors and tacho generator
module bsp_motor #(
  parameter int STEP = 50
) (
  input wire logic clk,
  input wire logic spin,
  input wire logic dir_sel,
  input wire logic hall_fault,
  input wire logic [15:0] tacho_per,
  output logic [2:0] hall,
  output logic tacho_pulse
);
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [2:0] SEQ [6] = '{3'h5, 3'h4, 3'h6, 3'h2, 3'h3, 3'h1};
  int pos = 0;
  int sc = 0;
  int tc = 0;
  initial begin
    hall = 3'h5;
    tacho_pulse = 1'b0;
  end
  // ==========================================================================
  // Rotor stands still while not driven, tacho too
  always @(posedge clk) begin
    if (spin) begin
      sc = sc + 1;
      tc = (tc + 1 >= int'(tacho_per)) ? 0 : tc + 1;
    end
    if (sc >= STEP) begin
      sc = 0;
      pos = dir_sel ? (pos + 5) % 6 : (pos + 1) % 6;
    end
    hall <= hall_fault ? 3'h0 : SEQ[pos];
    tacho_pulse <= spin && (tc < int'(tacho_per) / 2);
  end
endmodule : bsp_motor

/* test/test_bldc_speed_pwm_control.sv */
// Self-checking bench of the brushless speed and PWM control block
module test_bldc_speed_pwm_control import bsp_pkg::*; ;
  timeunit 1ns;
  timeprecision 1ns;
  typedef struct {bsp_drive_t exp; int t;} bsp_note_t;
  logic ref_clk = 1'b0;
  logic reset_n = 1'b0;
  logic dir = 1'b0, run = 1'b0, cur = 1'b0, ren = 1'b0, fault = 1'b0;
  logic [15:0] per = 16'h2000;
  logic [31:0] lfsr = 32'hca48;
  logic [2:0] hall, hall_prev = 3'h0;
  logic tacho, lock_n, psave, reg_on, latched;
  bsp_sense_t sense;
  bsp_drive_t drive;
  bsp_note_t note_q[$];
  bsp_note_t nt;
  int cyc = 0;
  int err_total = 0;
  int samples_checked = 0;

  assign sense = {hall, tacho, dir, run, cur, ren};
  always #20 ref_clk = ~ref_clk;

  bsp_top #(.PWM_PERIOD(16), .RESTRAINT_CYC(200)) dut_u (
    .ref_clk(ref_clk), .reset_n(reset_n), .sense(sense), .drive(drive),
    .lock_detect_out(lock_n), .power_save(psave),
    .regulator_output(reg_on), .restraint_latched(latched));
  bsp_motor motor_u (
    .clk(ref_clk), .spin(run), .dir_sel(dir), .hall_fault(fault),
    .tacho_per(per), .hall(hall), .tacho_pulse(tacho));

  // ==========================================================================
  // Helpers
  function automatic logic [31:0] lfsr_next(logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction : lfsr_next

  function automatic bsp_drive_t expect_drive(logic [2:0] h, logic d);
    logic [5:0] ul;
    case (h)
      3'h5: ul = {3'h1, 3'h2};
      3'h4: ul = {3'h1, 3'h4};
      3'h6: ul = {3'h2, 3'h4};
      3'h2: ul = {3'h2, 3'h1};
      3'h3: ul = {3'h4, 3'h1};
      3'h1: ul = {3'h4, 3'h2};
      default: ul = 6'h00;
    endcase
    return d ? {ul[2:0], ul[5:3]} : ul;
  endfunction : expect_drive

  task automatic check(string what, logic [7:0] exp, logic [7:0] seen);
    samples_checked++;
    if (seen !== exp) begin
      err_total++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic conclude();
    $display("checks %0d mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : conclude

  // ==========================================================================
  // Notes on every Hall change, compared after the sync delay
  always @(posedge ref_clk) begin
    cyc++;
    if (hall !== hall_prev) begin
      note_q.push_back('{run ? expect_drive(hall, dir) : bsp_drive_t'(6'h00),
        cyc + 7});
    end
    hall_prev = hall;
  end

  always @(negedge ref_clk) begin
    if (note_q.size() > 0 && cyc >= note_q[0].t) begin
      nt = note_q.pop_front();
      check("upper", 8'(nt.exp.upper), 8'(drive.upper));
      check("lower", 8'h0, 8'(drive.lower & ~nt.exp.lower));
    end
  end

  // ==========================================================================
  // Main sequence
  initial begin
    repeat (20) @(posedge ref_clk);
    reset_n <= 1'b1;
    repeat (8) @(posedge ref_clk);
    check("regulator", 8'h1, 8'(reg_on));
    check("power save", 8'h1, 8'(psave));
    $display("test reset done");
    lfsr = lfsr_next(lfsr);
    per <= 16'h2000 + 16'(lfsr[7:0]);
    run <= 1'b1;
    for (int i = 0; i < 24; i++) begin
      @(hall);
      repeat (25) @(posedge ref_clk);
      lfsr = lfsr_next(lfsr);
      cur <= lfsr[0];
      dir <= (i >= 12);
      fault <= (i == 6 || i == 18);
    end
    cur <= 1'b0;
    $display("test commutation done");
    repeat (33900) @(posedge ref_clk);
    check("lock in band", 8'h0, 8'(lock_n));
    // Duty is up by now, so a trip has a lower switch to cut
    cur <= 1'b1;
    repeat (10) @(posedge ref_clk);
    check("chop lower", 8'h0, 8'(drive.lower));
    cur <= 1'b0;
    per <= 16'h2000 + 16'h208;
    repeat (35500) @(posedge ref_clk);
    check("lock out band", 8'h1, 8'(lock_n));
    check("latch unarmed", 8'h0, 8'(latched));
    ren <= 1'b1;
    repeat (240) @(posedge ref_clk);
    check("latched", 8'h1, 8'(latched));
    check("lower off", 8'h0, 8'(drive.lower));
    @(hall);
    repeat (20) @(posedge ref_clk);
    run <= 1'b0;
    repeat (12) @(posedge ref_clk);
    check("released", 8'h0, 8'(latched));
    check("stop drive", 8'h0, 8'(drive));
    check("stop save", 8'h1, 8'(psave));
    check("stop reg", 8'h1, 8'(reg_on));
    $display("test lock and restraint done");
    conclude();
  end

  // Run should end near 71000 cycles
  initial begin
    repeat (90000) @(posedge ref_clk);
    err_total++;
    conclude();
  end
endmodule : test_bldc_speed_pwm_control
